/* logic/phy_mgmt_and_mode_control.v */
// management serial slave, control registers and mode steering
// assumes mdc/mdio come from another domain; core runs on clk_in
`timescale 1ns/1ps
`include "phy_mgmt_defs.vh"

module phy_mgmt_and_mode_control (
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       mdc_in,
	input  wire       mdio_in,
	output reg        mdio_out,
	output reg        mdio_oe_n_out,
	input  wire       addr_strap_in,
	input  wire [7:0] int_event_in,
	output reg        irq_out,
	input  wire       partner_mdix_in,
	input  wire       link_100fd_in,
	input  wire       tx_en_in,
	input  wire [1:0] txd_in,
	input  wire       line_rx_dv_in,
	input  wire [1:0] line_rxd_in,
	output reg        crs_dv_out,
	output reg  [1:0] rxd_out,
	output reg        line_tx_en_out,
	output reg  [1:0] line_txd_out,
	output reg        mdix_out,
	output reg        an_en_out,
	output reg        speed_100_out,
	output reg        full_duplex_out,
	output reg        ref50_out,
	output reg        b2b_out
);
	// ------------------------------------------------------------
	// states and registers
	// ------------------------------------------------------------
	localparam ST_IDLE = 5'b00001;
	localparam ST_HDR  = 5'b00010;
	localparam ST_TA   = 5'b00100;
	localparam ST_RD   = 5'b01000;
	localparam ST_WR   = 5'b10000;

	reg [4:0]  state_reg;
	reg [5:0]  ones_reg;
	reg [4:0]  cnt_reg;
	reg [13:0] hdr_reg;
	reg [15:0] shift_reg;
	reg        mine_reg;
	reg        first_reg;
	reg        mdc_s1_reg;
	reg        mdc_s2_reg;
	reg        mdc_prev_reg;
	reg        mdio_s1_reg;
	reg        mdio_s2_reg;
	reg        strap_s1_reg;
	reg        strap_s2_reg;
	reg [15:0] basic_ctrl_reg;
	reg [15:0] mode_ctrl_reg;
	reg [15:0] phy_ctrl2_reg;
	reg [7:0]  int_en_reg;
	reg [7:0]  int_flag_reg;
	reg        wr_pulse_reg;
	reg        rd_int_pulse_reg;
	reg [15:0] rd_word;
	wire [15:0] mem_rd_data;
	wire        mdc_rise;
	wire        mdc_fall;
	wire [4:0]  own_addr;
	wire [4:0]  hdr_phy;
	wire [4:0]  hdr_reg_idx;
	wire        addr_hit;
	wire        local_loop;
	wire        remote_loop;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// two flops on mdc, mdio and the strap pin; mdc resets to its parked high level
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			mdc_s1_reg   <= 1'b1;
			mdc_s2_reg   <= 1'b1;
			mdc_prev_reg <= 1'b1;
			mdio_s1_reg  <= 1'b1;
			mdio_s2_reg  <= 1'b1;
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
		end else begin
			mdc_s1_reg   <= mdc_in;
			mdc_s2_reg   <= mdc_s1_reg;
			mdc_prev_reg <= mdc_s2_reg;
			mdio_s1_reg  <= mdio_in;
			mdio_s2_reg  <= mdio_s1_reg;
			strap_s1_reg <= addr_strap_in;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	assign mdc_rise = mdc_s2_reg & ~mdc_prev_reg;
	assign mdc_fall = ~mdc_s2_reg & mdc_prev_reg;

	// ------------------------------------------------------------
	// address match
	// ------------------------------------------------------------
	// strap picks 0h or 3h; upper three bits always zero
	assign own_addr    = strap_s2_reg ? `ADDR_ALT : 5'h00;
	assign hdr_phy     = hdr_reg[9:5];
	assign hdr_reg_idx = hdr_reg[4:0];
	// 0h is broadcast until the mode bit turns it into a plain address
	assign addr_hit = (hdr_phy == own_addr) ||
		((hdr_phy == `ADDR_BCAST) &&
		 !mode_ctrl_reg[`BIT_BCAST_OFF]);

	// ------------------------------------------------------------
	// serial frame engine
	// ------------------------------------------------------------
	// bits sampled on mdc rise; read data launched on mdc fall so
	// the controller sees stable data at its next rising edge
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_reg        <= ST_IDLE;
			ones_reg         <= 6'd0;
			cnt_reg          <= 5'd0;
			hdr_reg          <= 14'h0000;
			shift_reg        <= 16'h0000;
			mine_reg         <= 1'b0;
			first_reg        <= 1'b0;
			mdio_out         <= 1'b1;
			mdio_oe_n_out    <= 1'b1;
			wr_pulse_reg     <= 1'b0;
			rd_int_pulse_reg <= 1'b0;
		end else begin
			wr_pulse_reg     <= 1'b0;
			rd_int_pulse_reg <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				mdio_oe_n_out <= 1'b1;
				if (mdc_rise) begin
					// start pattern 01 only after 32 ones
					if (mdio_s2_reg) begin
						if (ones_reg != `PREAMBLE_LEN)
							ones_reg <= ones_reg + 6'd1;
					end else begin
						if (ones_reg == `PREAMBLE_LEN) begin
							state_reg <= ST_HDR;
							cnt_reg   <= 5'd0;
							hdr_reg   <= 14'h0000;
						end
						ones_reg <= 6'd0;
					end
				end
			end
			ST_HDR: begin
				// second start bit, op, phy, reg = 13 bits
				if (mdc_rise) begin
					hdr_reg <= {hdr_reg[12:0], mdio_s2_reg};
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == `HDR_BITS - 5'd1) begin
						state_reg <= ST_TA;
						cnt_reg   <= 5'd0;
						first_reg <= 1'b1;
					end
				end
			end
			ST_TA: begin
				if (first_reg) begin
					first_reg <= 1'b0;
					mine_reg  <= addr_hit && hdr_reg[12] &&
						(hdr_reg[11:10] == `OP_READ ||
						 hdr_reg[11:10] == `OP_WRITE);
					// bad start bit or unknown op: ignore
					if (!hdr_reg[12])
						state_reg <= ST_IDLE;
				end else if (hdr_reg[11:10] == `OP_READ) begin
					// release on first ta bit, drive 0 on second
					if (mdc_fall) begin
						cnt_reg <= cnt_reg + 5'd1;
						if (cnt_reg == 5'd1 && mine_reg) begin
							mdio_out      <= 1'b0;
							mdio_oe_n_out <= 1'b0;
							shift_reg     <= rd_word;
							if (hdr_reg_idx == `REG_INT_CTRL)
								rd_int_pulse_reg <= 1'b1;
						end
						if (cnt_reg == 5'd1) begin
							state_reg <= ST_RD;
							cnt_reg   <= 5'd0;
						end
					end
				end else begin
					// write ta is driven by the controller
					if (mdc_rise) begin
						cnt_reg <= cnt_reg + 5'd1;
						if (cnt_reg == 5'd1) begin
							state_reg <= ST_WR;
							cnt_reg   <= 5'd0;
						end
					end
				end
			end
			ST_RD: begin
				// sixteen data bits msb first, then let go
				if (mdc_fall) begin
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == `DATA_BITS) begin
						mdio_oe_n_out <= 1'b1;
						mdio_out      <= 1'b1;
						state_reg     <= ST_IDLE;
						ones_reg      <= 6'd0;
					end else begin
						mdio_out  <= shift_reg[15];
						shift_reg <= {shift_reg[14:0], 1'b0};
						mdio_oe_n_out <= ~mine_reg;
					end
				end
			end
			ST_WR: begin
				if (mdc_rise) begin
					shift_reg <= {shift_reg[14:0], mdio_s2_reg};
					cnt_reg   <= cnt_reg + 5'd1;
					if (cnt_reg == `DATA_BITS - 5'd1) begin
						wr_pulse_reg <= mine_reg;
						state_reg    <= ST_IDLE;
						ones_reg     <= 6'd0;
					end
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	// plain standard words live in the small memory
	std_reg_mem #(.DEPTH(`IDX_REG_CNT), .AW(4)) u_std_mem (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.wr_en_in    (wr_pulse_reg && hdr_reg_idx < `IDX_REG_CNT &&
		              hdr_reg_idx != `REG_BASIC_CTRL),
		.wr_addr_in  (hdr_reg_idx[3:0]),
		.wr_data_in  (shift_reg),
		.rd_addr_in  (hdr_reg_idx[3:0]),
		.rd_data_out (mem_rd_data)
	);

	// read mux; memory data is ready well before ta ends
	always @* begin
		if (hdr_reg_idx == `REG_BASIC_CTRL)
			rd_word = basic_ctrl_reg;
		else if (hdr_reg_idx == `REG_MODE_CTRL)
			rd_word = mode_ctrl_reg;
		else if (hdr_reg_idx == `REG_INT_CTRL)
			rd_word = {int_en_reg, int_flag_reg};
		else if (hdr_reg_idx == `REG_PHY_CTRL2)
			rd_word = phy_ctrl2_reg;
		else if (hdr_reg_idx < `IDX_REG_CNT)
			rd_word = mem_rd_data;
		else
			rd_word = 16'h0000;
	end

	// control registers; flags are set by events and cleared by read
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			basic_ctrl_reg <= `RST_BASIC_CTRL;
			mode_ctrl_reg  <= `RST_MODE_CTRL;
			phy_ctrl2_reg  <= `RST_PHY_CTRL2;
			int_en_reg     <= 8'h00;
			int_flag_reg   <= 8'h00;
		end else begin
			if (wr_pulse_reg) begin
				if (hdr_reg_idx == `REG_BASIC_CTRL)
					basic_ctrl_reg <= shift_reg;
				else if (hdr_reg_idx == `REG_MODE_CTRL)
					mode_ctrl_reg <= shift_reg;
				else if (hdr_reg_idx == `REG_INT_CTRL)
					int_en_reg <= shift_reg[15:8];
				else if (hdr_reg_idx == `REG_PHY_CTRL2)
					phy_ctrl2_reg <= shift_reg;
			end
			// only flags that went out in the read word are cleared, so
			// an event after the word was latched still lands
			if (rd_int_pulse_reg)
				int_flag_reg <= int_event_in |
					(int_flag_reg & ~shift_reg[7:0]);
			else
				int_flag_reg <= int_flag_reg | int_event_in;
		end
	end

	// ------------------------------------------------------------
	// mode outputs
	// ------------------------------------------------------------
	assign local_loop = basic_ctrl_reg[`BIT_LOCAL_LOOP] &&
		!basic_ctrl_reg[`BIT_AN_EN] &&
		basic_ctrl_reg[`BIT_FULL_DUPLEX];
	// forced 100 full, or negotiated 100 full
	assign remote_loop = phy_ctrl2_reg[`BIT_REMOTE_LOOP] &&
		((!basic_ctrl_reg[`BIT_AN_EN] &&
		  basic_ctrl_reg[`BIT_SPEED_100] &&
		  basic_ctrl_reg[`BIT_FULL_DUPLEX]) ||
		 (basic_ctrl_reg[`BIT_AN_EN] && link_100fd_in));

	// registered steering of data and status outputs
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			irq_out         <= 1'b1;
			mdix_out        <= 1'b0;
			an_en_out       <= 1'b1;
			speed_100_out   <= 1'b1;
			full_duplex_out <= 1'b1;
			ref50_out       <= 1'b0;
			b2b_out         <= 1'b0;
			crs_dv_out      <= 1'b0;
			rxd_out         <= 2'b00;
			line_tx_en_out  <= 1'b0;
			line_txd_out    <= 2'b00;
		end else begin
			// active level chosen by control2, default low
			irq_out <= (|(int_en_reg & int_flag_reg)) ==
				phy_ctrl2_reg[`BIT_IRQ_HIGH];
			// auto follows partner, else forced bit
			mdix_out <= phy_ctrl2_reg[`BIT_XOVER_OFF] ?
				phy_ctrl2_reg[`BIT_MDIX_FORCE] : partner_mdix_in;
			an_en_out       <= basic_ctrl_reg[`BIT_AN_EN];
			speed_100_out   <= basic_ctrl_reg[`BIT_SPEED_100];
			full_duplex_out <= basic_ctrl_reg[`BIT_FULL_DUPLEX];
			ref50_out       <= phy_ctrl2_reg[`BIT_REF50];
			b2b_out <= mode_ctrl_reg[`BIT_B2B_A] &&
				mode_ctrl_reg[`BIT_B2B_B];
			// mac side receive: looped transmit or line data
			if (local_loop) begin
				crs_dv_out <= tx_en_in;
				rxd_out    <= tx_en_in ? txd_in : 2'b00;
			end else begin
				crs_dv_out <= line_rx_dv_in;
				rxd_out    <= line_rx_dv_in ? line_rxd_in : 2'b00;
			end
			// line side transmit: echoed line data, idle in local loopback, or mac data
			if (remote_loop) begin
				line_tx_en_out <= line_rx_dv_in;
				line_txd_out   <= line_rxd_in;
			end else if (local_loop) begin
				line_tx_en_out <= 1'b0;
				line_txd_out   <= 2'b00;
			end else begin
				line_tx_en_out <= tx_en_in;
				line_txd_out   <= tx_en_in ? txd_in : 2'b00;
			end
		end
	end
endmodule

/* logic/phy_mgmt_defs.vh */
// constants for the transceiver management and mode control block
// assumes inclusion by bare name from design files only
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define REG_BASIC_CTRL    5'h00
`define REG_BASIC_STAT    5'h01
`define REG_MODE_CTRL     5'h16
`define REG_INT_CTRL      5'h1B
`define REG_PHY_CTRL2     5'h1F
`define IDX_REG_CNT       9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_LOCAL_LOOP    14
`define BIT_SPEED_100     13
`define BIT_AN_EN         12
`define BIT_FULL_DUPLEX   8
`define BIT_BCAST_OFF     9
`define BIT_B2B_A         6
`define BIT_B2B_B         1
`define BIT_MDIX_FORCE    14
`define BIT_XOVER_OFF     13
`define BIT_IRQ_HIGH      9
`define BIT_REF50         7
`define BIT_REMOTE_LOOP   2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BASIC_CTRL    16'h3100
`define RST_MODE_CTRL     16'h0000
`define RST_INT_CTRL      16'h0000
`define RST_PHY_CTRL2     16'h0000
`define RST_STD_REG       16'h0000

// ----------------------------------------------------------------
// frame fields
// ----------------------------------------------------------------
`define PREAMBLE_LEN      6'd32
`define OP_READ           2'b10
`define OP_WRITE          2'b01
`define ADDR_ALT          5'h03
`define ADDR_BCAST        5'h00
`define HDR_BITS          5'd13
`define DATA_BITS         5'd16

`endif

/* logic/std_reg_mem.v */
// small register memory for the standard management registers
// assumes one writer and one reader on the same clock, registered read
`timescale 1ns/1ps
`include "phy_mgmt_defs.vh"

module std_reg_mem #(
	parameter DEPTH = 9,
	parameter AW    = 4
) (
	input  wire          clk_in,
	input  wire          rst_n_in,
	input  wire          wr_en_in,
	input  wire [AW-1:0] wr_addr_in,
	input  wire [15:0]   wr_data_in,
	input  wire [AW-1:0] rd_addr_in,
	output reg  [15:0]   rd_data_out
);
	reg [15:0] mem_reg [0:DEPTH-1];
	integer    i;

	// ------------------------------------------------------------
	// storage and registered read
	// ------------------------------------------------------------
	// write port; reset clears every word
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (i = 0; i < DEPTH; i = i + 1)
				mem_reg[i] <= `RST_STD_REG;
		end else if (wr_en_in) begin
			mem_reg[wr_addr_in] <= wr_data_in;
		end
	end

	// read data always comes out of a flop
	always @(posedge clk_in) begin
		if (!rst_n_in)
			rd_data_out <= `RST_STD_REG;
		else if (rd_addr_in < DEPTH)
			rd_data_out <= mem_reg[rd_addr_in];
		else
			rd_data_out <= `RST_STD_REG;
	end
endmodule

/* bench/phy_mgmt_checker_properties.sv */
// pin-level checks for the management and mode control block
// assumes the bench clocks management bits at 8 core cycles, parked high
`timescale 1ns/1ps
module phy_mgmt_checker (
	input logic       clk_in,
	input logic       rst_n_in,
	input logic       mdc_in,
	input logic       mdio_out,
	input logic       mdio_oe_n_out,
	input logic [7:0] int_event_in,
	input logic       irq_out,
	input logic       tx_en_in,
	input logic       line_rx_dv_in,
	input logic       crs_dv_out,
	input logic       line_tx_en_out,
	input logic       an_en_out,
	input logic       speed_100_out,
	input logic       full_duplex_out,
	input logic       ref50_out,
	input logic       b2b_out
);
	logic [7:0] hi_cnt;
	logic [7:0] drv_cnt;
	logic       ev_any;
	logic       rx_tx_any;
	// ----------
	// helpers
	// ----------
	// quiet time with the clock parked, and length of a read drive
	assign ev_any    = |int_event_in;
	assign rx_tx_any = tx_en_in | line_rx_dv_in;
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			hi_cnt  <= 8'h00;
			drv_cnt <= 8'h00;
		end else begin
			hi_cnt  <= !mdc_in ? 8'h00 :
				(hi_cnt[6] ? hi_cnt : hi_cnt + 8'h01);
			drv_cnt <= mdio_oe_n_out ? 8'h00 : drv_cnt + 8'h01;
		end
	end
	// ----------
	// properties
	// ----------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_reset_levels: assert property (
		$rose(rst_n_in) |-> an_en_out && speed_100_out && full_duplex_out
			&& irq_out && !ref50_out && !b2b_out && mdio_oe_n_out)
		else $error("outputs wrong after reset");
	chk_ta_zero: assert property (
		$fell(mdio_oe_n_out) |-> !mdio_out)
		else $error("turnaround not driven low");
	chk_drive_span: assert property (
		$rose(mdio_oe_n_out) |-> drv_cnt inside {[8'h87:8'h89]})
		else $error("read drive not seventeen bits long");
	chk_quiet_release: assert property (
		hi_cnt > 8'h06 |-> mdio_oe_n_out)
		else $error("line driven while clock parked");
	chk_irq_cause: assert property (
		$changed(irq_out) && hi_cnt > 8'h06 |->
			$past(ev_any) || $past(ev_any, 2) || $past(ev_any, 3))
		else $error("interrupt moved with no event");
	chk_mode_quiet: assert property (
		$changed({an_en_out, speed_100_out, full_duplex_out, ref50_out,
			b2b_out}) |-> hi_cnt < 8'h06)
		else $error("mode output moved outside a write");
	chk_rx_cause: assert property (
		$rose(crs_dv_out) |-> $past(rx_tx_any) || $past(rx_tx_any, 2))
		else $error("receive valid with no source");
	chk_line_tx_cause: assert property (
		$rose(line_tx_en_out) |-> $past(rx_tx_any) || $past(rx_tx_any, 2))
		else $error("line transmit with no source");
	cov_read_drive: cover property ($fell(mdio_oe_n_out));
	cov_irq_move: cover property ($changed(irq_out) && hi_cnt > 8'h06);
	cov_line_tx: cover property ($rose(line_tx_en_out));
endmodule

bind phy_mgmt_and_mode_control phy_mgmt_checker i_phy_mgmt_checker (.*);

/* bench/mdio_manager.sv */
// management station model: drives clock and data pins in frames
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/1ps
module mdio_manager (
	input  logic clk_in,
	input  logic mdio_in,
	output logic mdc_out,
	output logic drv_en_out,
	output logic drv_val_out
);
	// ----------
	// serial bits
	// ----------
	// clock parks high between frames so the device sees no edges
	initial begin
		mdc_out     = 1'b1;
		drv_en_out  = 1'b0;
		drv_val_out = 1'b1;
	end

	// change on the fall, sample late in the high half for margin
	task automatic bit_cycle(input logic en, d, output logic s);
		drv_en_out  = en;
		drv_val_out = d;
		mdc_out     = 1'b0;
		repeat (4) @(negedge clk_in);
		mdc_out = 1'b1;
		repeat (4) @(negedge clk_in);
		s = mdio_in;
	endtask

	// one frame; ta returns both turnaround levels seen
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, idx,
		input logic [15:0] wd, output logic [15:0] rd,
		output logic [1:0] ta);
		logic [45:0] hdr;
		logic        wr;
		logic        s;
		hdr = {32'hffff_ffff, 2'h1, op, phy, idx};
		wr  = op == 2'h1;
		for (int i = 45; i >= 0; i--)
			bit_cycle(1'b1, hdr[i], s);
		// a read frees the line for turnaround
		bit_cycle(wr, 1'b1, ta[1]);
		bit_cycle(wr, 1'b0, ta[0]);
		for (int i = 15; i >= 0; i--)
			bit_cycle(wr, wd[i], rd[i]);
		bit_cycle(1'b0, 1'b1, s);
	endtask
endmodule

/* bench/tb.sv */
// self-checking bench for the management and mode control block
// assumes the manager model and the checker are compiled first
`timescale 1ns/1ps
module tb;
	logic        clk_in          = 1'b0;
	logic        rst_n_in        = 1'b0;
	logic        addr_strap_in   = 1'b1;
	logic [7:0]  int_event_in    = 8'h00;
	logic        partner_mdix_in = 1'b0;
	logic        link_100fd_in   = 1'b0;
	logic        tx_en_in        = 1'b0;
	logic        line_rx_dv_in   = 1'b0;
	logic [1:0]  txd_in          = 2'h0;
	logic [1:0]  line_rxd_in     = 2'h0;
	logic        bcast           = 1'b1;
	logic [31:0] seed            = 32'h0000_650d;
	logic        mdc, drv_en, drv_val, mdio, mdio_out, mdio_oe_n_out;
	logic        irq_out, crs_dv_out, line_tx_en_out, mdix_out, an_en_out;
	logic        speed_100_out, full_duplex_out, ref50_out, b2b_out;
	logic [1:0]  rxd_out, line_txd_out, ta;
	logic [15:0] rd;
	logic [31:0] v;
	int          miscompares = 0;
	int          checked     = 0;

	// released line floats high through the pull-up
	assign mdio = !mdio_oe_n_out ? mdio_out : drv_en ? drv_val : 1'b1;
	always #50 clk_in = ~clk_in;
	mdio_manager i_mdio_manager (.clk_in, .mdio_in(mdio), .mdc_out(mdc),
		.drv_en_out(drv_en), .drv_val_out(drv_val));
	phy_mgmt_and_mode_control i_phy_mgmt_and_mode_control (.*,
		.mdc_in(mdc), .mdio_in(mdio));

	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// strapped address, or zero while broadcast is still on
	function automatic logic hit(input logic [4:0] phy);
		return phy == {3'h0, {2{addr_strap_in}}}
			|| (phy == 5'h00 && bcast);
	endfunction
	task automatic check(input logic [15:0] seen, exp, input string s);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s %h %h", $time, s, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] phy, idx, input logic [15:0] d);
		i_mdio_manager.frame(2'h1, phy, idx, d, rd, ta);
	endtask
	// unanswered reads see the pull-up on every bit
	task automatic rdchk(input logic [4:0] phy, idx, input logic [15:0] e);
		i_mdio_manager.frame(2'h2, phy, idx, 16'h0000, rd, ta);
		check(rd, hit(phy) ? e : 16'hffff, "read data");
		check({14'h0000, ta}, hit(phy) ? 16'h0002 : 16'h0003,
			"turnaround");
	endtask
	// event pulse after a quiet spell, then time for the flag to land
	task automatic pulse(input int k);
		repeat (8) @(negedge clk_in);
		int_event_in = 8'h01 << k;
		@(negedge clk_in);
		int_event_in = 8'h00;
		repeat (3) @(negedge clk_in);
	endtask
	task automatic tend(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------
	// tests
	// ----------
	initial begin
		repeat (4) @(negedge clk_in);
		rst_n_in = 1'b1;
		@(negedge clk_in);
		check({an_en_out, speed_100_out, full_duplex_out, irq_out,
			ref50_out, b2b_out}, 6'h3c, "reset levels");
		rdchk(5'h03, 5'h00, 16'h3100);
		rdchk(5'h00, 5'h00, 16'h3100);
		rdchk(5'h13, 5'h00, 16'h3100);
		// an unknown op code must leave the line alone
		i_mdio_manager.frame(2'h3, 5'h03, 5'h00, 16'h0000, rd, ta);
		check(rd, 16'hffff, "other op");
		for (int i = 2; i <= 8; i++) begin
			v = xorshift();
			wr(5'h03, i[4:0], v[15:0]);
			rdchk(5'h03, i[4:0], v[15:0]);
		end
		tend("registers");
		for (int i = 1; i >= 0; i--) begin
			partner_mdix_in = i[0];
			repeat (8) @(negedge clk_in);
			check(mdix_out, i[0], "auto pairs");
		end
		partner_mdix_in = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(5'h03, 5'h1f, {1'b0, i[0], 1'b1, 5'h00, i[1], 7'h00});
			check({mdix_out, ref50_out}, {i[0], i[1]}, "pairs");
		end
		tend("pairs");
		wr(5'h03, 5'h1b, 16'hff00);
		for (int i = 0; i < 8; i++) begin
			pulse(i);
			check(irq_out, 1'b0, "irq raised");
			rdchk(5'h03, 5'h1b, {8'hff, 8'h01 << i});
			check(irq_out, 1'b1, "irq after read");
		end
		rdchk(5'h03, 5'h1b, 16'hff00);
		wr(5'h03, 5'h1b, 16'hfe00);
		wr(5'h03, 5'h1f, 16'h0200);
		check(irq_out, 1'b0, "idle in high mode");
		pulse(0);
		check(irq_out, 1'b0, "masked event");
		pulse(1);
		check(irq_out, 1'b1, "active high");
		rdchk(5'h03, 5'h1b, 16'hfe03);
		tend("interrupt");
		wr(5'h03, 5'h00, 16'h4100);
		check({an_en_out, speed_100_out, full_duplex_out}, 3'h1, "forced");
		for (int i = 0; i < 4; i++) begin
			v = xorshift();
			{tx_en_in, txd_in} = {1'b1, v[1:0]};
			repeat (3) @(negedge clk_in);
			check({crs_dv_out, rxd_out}, {1'b1, v[1:0]}, "local");
		end
		wr(5'h03, 5'h00, 16'h4000);
		check(crs_dv_out, 1'b0, "half duplex loop");
		{tx_en_in, line_rx_dv_in} = 2'h1;
		wr(5'h03, 5'h1f, 16'h0004);
		for (int i = 0; i < 3; i++) begin
			link_100fd_in = i == 2;
			wr(5'h03, 5'h00, i == 0 ? 16'h2100 : i == 1 ? 16'h0100 : 16'h1000);
			v = xorshift();
			line_rxd_in = v[1:0];
			repeat (3) @(negedge clk_in);
			check({line_tx_en_out, line_txd_out},
				i == 1 ? 3'h0 : {1'b1, v[1:0]}, "remote");
		end
		tend("loopback");
		wr(5'h03, 5'h1f, 16'h0080);
		wr(5'h03, 5'h16, 16'h0202);
		bcast = 1'b0;
		check(b2b_out, 1'b0, "one repeater bit");
		wr(5'h03, 5'h16, 16'h0242);
		check({b2b_out, ref50_out}, 2'h3, "repeater on");
		v = xorshift();
		{tx_en_in, txd_in, line_rxd_in} = {1'b1, v[3:0]};
		repeat (3) @(negedge clk_in);
		check({crs_dv_out, rxd_out, line_tx_en_out, line_txd_out},
			{1'b1, v[1:0], 1'b1, v[3:2]}, "repeater");
		rdchk(5'h00, 5'h16, 16'h0242);
		rdchk(5'h03, 5'h16, 16'h0242);
		tend("repeater");
		// strap low: own address becomes 0h, 3h goes unanswered
		addr_strap_in = 1'b0;
		repeat (4) @(negedge clk_in);
		rdchk(5'h00, 5'h16, 16'h0242);
		rdchk(5'h03, 5'h16, 16'h0242);
		tend("strap");
		finish_test();
	end

	// hang guard, about 2.4 times the expected run
	initial begin
		#6_000_000;
		miscompares++;
		finish_test();
	end
endmodule
